// [lsce_consts.vh]
// Constants for the linear sensor command engine: command codes, register addresses, delays.
`ifndef LSCE_CONSTS_VH
`define LSCE_CONSTS_VH

// Action command bytes.
`define LSCE_CMD_MAIN_RESET 8'h1b
`define LSCE_CMD_BEGIN_EXPOSURE 8'h08
`define LSCE_CMD_CAPTURE_EXPOSURE 8'h10
`define LSCE_CMD_STREAM_SAMPLES 8'h02
`define LSCE_CMD_CANCEL_STREAM 8'h19
`define LSCE_CMD_CAPTURE_AND_STREAM 8'h12
`define LSCE_CMD_CAPTURE_STREAM_RESTART 8'h16

// Register command prefixes in bits 7:5 and the address field.
`define LSCE_PFX_SETTING_STORE 3'h2
`define LSCE_PFX_SETTING_FETCH 3'h3
`define LSCE_ADDR_MSB 4

// Register addresses.
`define LSCE_ADDR_LEFT_OFFSET 5'h00
`define LSCE_ADDR_LEFT_GAIN 5'h01
`define LSCE_ADDR_CENTER_OFFSET 5'h02
`define LSCE_ADDR_CENTER_GAIN 5'h03
`define LSCE_ADDR_RIGHT_OFFSET 5'h04
`define LSCE_ADDR_RIGHT_GAIN 5'h05
`define LSCE_ADDR_MODE 5'h1f

// Register widths and field positions.
`define LSCE_OFFSET_W 8
`define LSCE_GAIN_W 5
`define LSCE_MODE_SLEEP_BIT 4
`define LSCE_OFFSET_RESET 8'h00
`define LSCE_GAIN_RESET 5'h00
`define LSCE_MODE_RESET 8'h00

// Timing counts, in serial clocks.
`define LSCE_BREAK_LEN 10
`define LSCE_EXPOSE_DELAY 22
`define LSCE_STREAM_DELAY 44
`define LSCE_FETCH_DELAY 4
`define LSCE_OUT_VALID_DELAY 30

// Pixel count and frame layout.
`define LSCE_PIXELS 102
`define LSCE_DATA_BITS 8
`define LSCE_FRAME_TAIL 9

`endif

// [lsce_ctrl_model.sv]
// Controller-side model: drives the serial command line and answers the pixel converter.
`timescale 1ns/1ps
module lsce_ctrl_model (
    // Clock
    input wire mclk,
    // Serial command line
    output reg serial_in,
    // Pixel converter
    input wire [6:0] pixel_sel,
    output wire [7:0] pixel_code
);
    // Every pixel gets its own code, so an order slip shows in the data.
    assign pixel_code = {pixel_sel, 1'b0} ^ 8'h5a;
    initial serial_in = 1'b1;
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // The stop bit is left on the line; the gap argument adds that many further idle clocks after it.
    task automatic send_byte(input logic [7:0] b, input int gap);
        @(posedge mclk) serial_in <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk) serial_in <= b[i];
        end
        @(posedge mclk) serial_in <= 1'b1;
        repeat (gap) @(posedge mclk);
    endtask
    // Holds the line low for n clocks, a break when n is ten or more.
    task automatic send_break(input int n);
        @(posedge mclk) serial_in <= 1'b0;
        repeat (n) @(posedge mclk);
        serial_in <= 1'b1;
    endtask
endmodule

// [lsce_engine.v]
// Serial command interpreter and sequencer for a 102-pixel linear image sensor.
`timescale 1ns/1ps
`include "lsce_consts.vh"

module lsce_engine #(
    parameter PIXELS = `LSCE_PIXELS,
    parameter EXPOSE_DELAY = `LSCE_EXPOSE_DELAY,
    parameter STREAM_DELAY = `LSCE_STREAM_DELAY,
    parameter FETCH_DELAY = `LSCE_FETCH_DELAY
) (
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // Serial link
    input wire serial_in,
    output reg serial_out,
    output reg serial_out_valid,
    // Pixel converter
    output reg [6:0] pixel_sel,
    input wire [7:0] pixel_code,
    // Analog array control
    output reg pix_reset,
    output reg integrating,
    output reg capture_strobe,
    output reg hold_valid,
    output reg sleep_mode,
    // Zone and mode settings
    output reg [7:0] left_offset,
    output reg [4:0] left_gain,
    output reg [7:0] center_offset,
    output reg [4:0] center_gain,
    output reg [7:0] right_offset,
    output reg [4:0] right_gain,
    output reg [7:0] mode_setting
);

    localparam RX_IDLE = 2'h0;
    localparam RX_DATA = 2'h1;
    localparam RX_BREAK = 2'h2;

    localparam TX_IDLE = 2'h0;
    localparam TX_WAIT = 2'h1;
    localparam TX_FRAME = 2'h2;
    localparam TX_NEXT = 2'h3;

    localparam [6:0] LAST_PIXEL = PIXELS - 1;
    localparam [5:0] STREAM_WAIT = STREAM_DELAY - 1;
    localparam [5:0] FETCH_WAIT = FETCH_DELAY - 1;
    localparam [4:0] EXPOSE_WAIT = EXPOSE_DELAY - 1;
    localparam [3:0] FRAME_TAIL = `LSCE_FRAME_TAIL;
    localparam [4:0] VALID_WAIT = `LSCE_OUT_VALID_DELAY - 1;

    // Receiver state.
    reg [1:0] rx_state_reg;
    reg [2:0] rx_bit_reg;
    reg [7:0] rx_shift_reg;
    reg [3:0] zero_run_reg;
    reg byte_done_reg;
    reg [7:0] byte_reg;

    // Command tracking.
    reg expect_data_reg;
    reg [4:0] store_addr_reg;

    // Transmitter state.
    reg [1:0] tx_state_reg;
    reg [5:0] tx_wait_reg;
    reg [3:0] tx_bits_reg;
    reg [8:0] tx_shift_reg;
    reg tx_stream_reg;
    reg [7:0] tx_fetch_reg;

    // Exposure sequencing and output qualification.
    reg expose_pending_reg;
    reg [4:0] expose_cnt_reg;
    reg seen_reset_reg;
    reg [4:0] valid_cnt_reg;

    // Decoded command of the byte that just finished.
    wire is_cmd = byte_done_reg && !expect_data_reg;
    wire [7:0] cmd = byte_reg;
    wire cmd_reset = is_cmd && cmd == `LSCE_CMD_MAIN_RESET;
    wire cmd_cancel = is_cmd && cmd == `LSCE_CMD_CANCEL_STREAM;
    wire cmd_restart = is_cmd && cmd == `LSCE_CMD_CAPTURE_STREAM_RESTART;
    wire cmd_capture = is_cmd && (cmd == `LSCE_CMD_CAPTURE_EXPOSURE ||
        cmd == `LSCE_CMD_CAPTURE_AND_STREAM || cmd == `LSCE_CMD_CAPTURE_STREAM_RESTART);
    wire cmd_stream = is_cmd && (cmd == `LSCE_CMD_STREAM_SAMPLES ||
        cmd == `LSCE_CMD_CAPTURE_AND_STREAM || cmd == `LSCE_CMD_CAPTURE_STREAM_RESTART);
    wire cmd_expose = is_cmd && (cmd == `LSCE_CMD_BEGIN_EXPOSURE || cmd_restart);
    wire cmd_store = is_cmd && cmd[7:5] == `LSCE_PFX_SETTING_STORE;
    wire cmd_fetch = is_cmd && cmd[7:5] == `LSCE_PFX_SETTING_FETCH;
    wire cmd_kill = cmd_reset || cmd_cancel;
    wire break_now = !serial_in && zero_run_reg == `LSCE_BREAK_LEN - 1;

    // Register read multiplexer; unmapped addresses read as zero.
    reg [7:0] fetch_data;
    always @* begin
        fetch_data = 8'h00;
        if (cmd[`LSCE_ADDR_MSB:0] == `LSCE_ADDR_LEFT_OFFSET) begin
            fetch_data = left_offset;
        end else if (cmd[`LSCE_ADDR_MSB:0] == `LSCE_ADDR_LEFT_GAIN) begin
            fetch_data = {3'h0, left_gain};
        end else if (cmd[`LSCE_ADDR_MSB:0] == `LSCE_ADDR_CENTER_OFFSET) begin
            fetch_data = center_offset;
        end else if (cmd[`LSCE_ADDR_MSB:0] == `LSCE_ADDR_CENTER_GAIN) begin
            fetch_data = {3'h0, center_gain};
        end else if (cmd[`LSCE_ADDR_MSB:0] == `LSCE_ADDR_RIGHT_OFFSET) begin
            fetch_data = right_offset;
        end else if (cmd[`LSCE_ADDR_MSB:0] == `LSCE_ADDR_RIGHT_GAIN) begin
            fetch_data = {3'h0, right_gain};
        end else if (cmd[`LSCE_ADDR_MSB:0] == `LSCE_ADDR_MODE) begin
            fetch_data = mode_setting;
        end
    end

    // Receiver. A break parks it until the line returns high, so the trailing
    // zeros of the break cannot be mistaken for a start bit.
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rx_state_reg <= RX_IDLE;
            rx_bit_reg <= 3'h0;
            rx_shift_reg <= 8'h00;
            zero_run_reg <= 4'h0;
            byte_done_reg <= 1'b0;
            byte_reg <= 8'h00;
        end else begin
            byte_done_reg <= 1'b0;
            if (serial_in) begin
                zero_run_reg <= 4'h0;
            end else if (zero_run_reg != 4'hf) begin
                zero_run_reg <= zero_run_reg + 4'h1;
            end
            if (break_now) begin
                rx_state_reg <= RX_BREAK;
            end else begin
                case (rx_state_reg)
                    RX_IDLE: begin
                        if (!serial_in) begin
                            rx_state_reg <= RX_DATA;
                            rx_bit_reg <= 3'h0;
                        end
                    end
                    RX_DATA: begin
                        rx_shift_reg <= {serial_in, rx_shift_reg[7:1]};
                        rx_bit_reg <= rx_bit_reg + 3'h1;
                        if (rx_bit_reg == `LSCE_DATA_BITS - 1) begin
                            // No stop bit is awaited; the next zero may be a start.
                            rx_state_reg <= RX_IDLE;
                            byte_done_reg <= 1'b1;
                            byte_reg <= {serial_in, rx_shift_reg[7:1]};
                        end
                    end
                    RX_BREAK: begin
                        if (serial_in) begin
                            rx_state_reg <= RX_IDLE;
                        end
                    end
                    default: begin
                        rx_state_reg <= RX_IDLE;
                    end
                endcase
            end
        end
    end

    // Command tracker and settings. Only received bytes cause actions.
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            expect_data_reg <= 1'b0;
            store_addr_reg <= 5'h00;
            left_offset <= `LSCE_OFFSET_RESET;
            left_gain <= `LSCE_GAIN_RESET;
            center_offset <= `LSCE_OFFSET_RESET;
            center_gain <= `LSCE_GAIN_RESET;
            right_offset <= `LSCE_OFFSET_RESET;
            right_gain <= `LSCE_GAIN_RESET;
            mode_setting <= `LSCE_MODE_RESET;
            sleep_mode <= 1'b0;
        end else begin
            sleep_mode <= mode_setting[`LSCE_MODE_SLEEP_BIT];
            if (rx_state_reg == RX_BREAK || break_now) begin
                expect_data_reg <= 1'b0;
            end else if (byte_done_reg && expect_data_reg) begin
                expect_data_reg <= 1'b0;
                if (store_addr_reg == `LSCE_ADDR_LEFT_OFFSET) begin
                    left_offset <= byte_reg;
                end else if (store_addr_reg == `LSCE_ADDR_LEFT_GAIN) begin
                    left_gain <= byte_reg[`LSCE_GAIN_W-1:0];
                end else if (store_addr_reg == `LSCE_ADDR_CENTER_OFFSET) begin
                    center_offset <= byte_reg;
                end else if (store_addr_reg == `LSCE_ADDR_CENTER_GAIN) begin
                    center_gain <= byte_reg[`LSCE_GAIN_W-1:0];
                end else if (store_addr_reg == `LSCE_ADDR_RIGHT_OFFSET) begin
                    right_offset <= byte_reg;
                end else if (store_addr_reg == `LSCE_ADDR_RIGHT_GAIN) begin
                    right_gain <= byte_reg[`LSCE_GAIN_W-1:0];
                end else if (store_addr_reg == `LSCE_ADDR_MODE) begin
                    mode_setting <= byte_reg;
                end
            end else if (cmd_store) begin
                expect_data_reg <= 1'b1;
                store_addr_reg <= cmd[`LSCE_ADDR_MSB:0];
            end
            // Any other byte is a one-byte action or ignored outright.
        end
    end

    // Exposure sequencing: capture, release after the pixel reset cycle, abort.
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pix_reset <= 1'b1;
            integrating <= 1'b0;
            capture_strobe <= 1'b0;
            hold_valid <= 1'b0;
            expose_pending_reg <= 1'b0;
            expose_cnt_reg <= 5'h00;
        end else begin
            capture_strobe <= 1'b0;
            if (cmd_kill) begin
                pix_reset <= 1'b1;
                integrating <= 1'b0;
                hold_valid <= 1'b0;
                expose_pending_reg <= 1'b0;
            end else begin
                if (cmd_capture) begin
                    capture_strobe <= 1'b1;
                    hold_valid <= 1'b1;
                    integrating <= 1'b0;
                    pix_reset <= 1'b1;
                end
                if (cmd_expose) begin
                    // A restart follows its own capture within the same byte.
                    expose_pending_reg <= 1'b1;
                    expose_cnt_reg <= EXPOSE_WAIT;
                    if (!cmd_capture) begin
                        pix_reset <= 1'b1;
                        integrating <= 1'b0;
                    end
                end else if (expose_pending_reg) begin
                    expose_cnt_reg <= expose_cnt_reg - 5'h01;
                    if (expose_cnt_reg == 5'h00) begin
                        expose_pending_reg <= 1'b0;
                        pix_reset <= 1'b0;
                        integrating <= 1'b1;
                    end
                end
            end
        end
    end

    // Transmitter. It runs apart from the receiver, so bytes keep being taken
    // during a stream; a fetch issued mid-stream replaces the stream.
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tx_state_reg <= TX_IDLE;
            tx_wait_reg <= 6'h00;
            tx_bits_reg <= 4'h0;
            tx_shift_reg <= 9'h1ff;
            tx_stream_reg <= 1'b0;
            tx_fetch_reg <= 8'h00;
            pixel_sel <= 7'h00;
            serial_out <= 1'b1;
        end else if (cmd_kill) begin
            tx_state_reg <= TX_IDLE;
            tx_stream_reg <= 1'b0;
            serial_out <= 1'b1;
        end else if (cmd_stream) begin
            tx_state_reg <= TX_WAIT;
            tx_wait_reg <= STREAM_WAIT;
            tx_stream_reg <= 1'b1;
            pixel_sel <= 7'h00;
            serial_out <= 1'b1;
        end else if (cmd_fetch) begin
            tx_state_reg <= TX_WAIT;
            tx_wait_reg <= FETCH_WAIT;
            tx_stream_reg <= 1'b0;
            tx_fetch_reg <= fetch_data;
            serial_out <= 1'b1;
        end else begin
            case (tx_state_reg)
                TX_IDLE: begin
                    serial_out <= 1'b1;
                end
                TX_WAIT: begin
                    tx_wait_reg <= tx_wait_reg - 6'h01;
                    if (tx_wait_reg == 6'h00) begin
                        serial_out <= 1'b0;
                        tx_shift_reg <= {1'b1, tx_stream_reg ? pixel_code : tx_fetch_reg};
                        tx_bits_reg <= FRAME_TAIL;
                        tx_state_reg <= TX_FRAME;
                    end
                end
                TX_FRAME: begin
                    serial_out <= tx_shift_reg[0];
                    tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
                    tx_bits_reg <= tx_bits_reg - 4'h1;
                    if (tx_bits_reg == 4'h1) begin
                        tx_state_reg <= TX_NEXT;
                        if (tx_stream_reg && pixel_sel != LAST_PIXEL) begin
                            pixel_sel <= pixel_sel + 7'h01;
                        end else begin
                            tx_stream_reg <= 1'b0;
                        end
                    end
                end
                TX_NEXT: begin
                    // One stop bit between pixels: the next start follows at once.
                    if (tx_stream_reg) begin
                        serial_out <= 1'b0;
                        tx_shift_reg <= {1'b1, pixel_code};
                        tx_bits_reg <= FRAME_TAIL;
                        tx_state_reg <= TX_FRAME;
                    end else begin
                        serial_out <= 1'b1;
                        tx_state_reg <= TX_IDLE;
                    end
                end
                default: begin
                    tx_state_reg <= TX_IDLE;
                end
            endcase
        end
    end

    // Output qualification after the first main reset.
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            seen_reset_reg <= 1'b0;
            valid_cnt_reg <= 5'h00;
            serial_out_valid <= 1'b0;
        end else if (cmd_reset && !seen_reset_reg) begin
            seen_reset_reg <= 1'b1;
            valid_cnt_reg <= VALID_WAIT;
        end else if (seen_reset_reg && !serial_out_valid) begin
            valid_cnt_reg <= valid_cnt_reg - 5'h01;
            if (valid_cnt_reg == 5'h00) begin
                serial_out_valid <= 1'b1;
            end
        end
    end

endmodule

// [lsce_engine_checker.sv]
// Concurrent checks on the ports of the linear sensor command engine.
`timescale 1ns/1ps
module lsce_engine_checker #(
    parameter PIXELS = 102
) (
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // Serial output
    input wire serial_out,
    input wire serial_out_valid,
    // Converter and array control
    input wire [6:0] pixel_sel,
    input wire pix_reset,
    input wire integrating,
    input wire capture_strobe,
    input wire hold_valid,
    input wire sleep_mode,
    input wire [7:0] mode_setting
);
    // Position inside an outgoing frame; 9 marks the stop bit.
    reg [3:0] bit_pos_reg;
    reg [3:0] bit_pos_next;
    always @* begin
        if (bit_pos_reg == 4'h9) begin
            bit_pos_next = 4'h0;
        end else if (bit_pos_reg != 4'h0 || !serial_out) begin
            bit_pos_next = bit_pos_reg + 4'h1;
        end else begin
            bit_pos_next = bit_pos_reg;
        end
    end
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            bit_pos_reg <= 4'h0;
        end else begin
            bit_pos_reg <= bit_pos_next;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    capture_pulse_a: assert property (
        capture_strobe |=> !capture_strobe) else $error("Capture strobe too long.");
    capture_state_a: assert property (
        capture_strobe |-> hold_valid && pix_reset && !integrating) else $error("Bad capture.");
    exclusive_state_a: assert property (
        !(pix_reset && integrating)) else $error("Reset and integration together.");
    release_start_a: assert property (
        $fell(pix_reset) |-> integrating) else $error("Release without integration.");
    hold_drop_a: assert property (
        $fell(hold_valid) |-> pix_reset && !integrating) else $error("Hold lost without abort.");
    sleep_follow_a: assert property (
        sleep_mode == $past(mode_setting[4])) else $error("Sleep does not follow mode.");
    stop_bit_a: assert property (
        bit_pos_reg == 4'h9 |-> serial_out) else $error("Missing stop bit.");
    valid_stays_a: assert property (
        !$fell(serial_out_valid)) else $error("Output qualifier dropped.");
    pixel_range_a: assert property (
        pixel_sel < PIXELS) else $error("Pixel index out of range.");
    pixel_step_a: assert property (
        $changed(pixel_sel) |-> pixel_sel == $past(pixel_sel) + 7'h01 || pixel_sel == 7'h00)
        else $error("Pixel index skipped.");
    step_at_stop_a: assert property (
        $changed(pixel_sel) && pixel_sel != 7'h00 |-> bit_pos_reg == 4'h9)
        else $error("Pixel step away from stop bit.");
endmodule

bind lsce_engine lsce_engine_checker #(.PIXELS(PIXELS)) u_checker (
    .mclk(mclk), .reset_n(reset_n), .serial_out(serial_out),
    .serial_out_valid(serial_out_valid), .pixel_sel(pixel_sel), .pix_reset(pix_reset),
    .integrating(integrating), .capture_strobe(capture_strobe), .hold_valid(hold_valid),
    .sleep_mode(sleep_mode), .mode_setting(mode_setting));

// [test_linear_sensor_command_engine.sv]
// Self-checking testbench of the linear sensor command engine.
`timescale 1ns/1ps
`include "lsce_consts.vh"
module test_linear_sensor_command_engine;
    `define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
        $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    wire serial_in, serial_out, serial_out_valid, pix_reset, integrating;
    wire capture_strobe, hold_valid, sleep_mode;
    wire [6:0] pixel_sel;
    wire [7:0] pixel_code, left_offset, center_offset, right_offset, mode_setting;
    wire [4:0] left_gain, center_gain, right_gain;
    int mismatches = 0;
    int n_checks = 0;
    int lat, lat2;
    logic [7:0] d;
    // Rows: address, stored byte, byte read back.
    logic [20:0] rows [7] = '{{5'h00, 8'h81, 8'h81}, {5'h01, 8'hff, 8'h1f},
        {5'h02, 8'h7e, 8'h7e}, {5'h03, 8'h0a, 8'h0a}, {5'h04, 8'hc3, 8'hc3},
        {5'h05, 8'h15, 8'h15}, {5'h07, 8'h55, 8'h00}};
    always #20 mclk = ~mclk;
    lsce_engine u_dut (.mclk(mclk), .reset_n(reset_n), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_valid(serial_out_valid),
        .pixel_sel(pixel_sel), .pixel_code(pixel_code), .pix_reset(pix_reset),
        .integrating(integrating), .capture_strobe(capture_strobe),
        .hold_valid(hold_valid), .sleep_mode(sleep_mode), .left_offset(left_offset),
        .left_gain(left_gain), .center_offset(center_offset), .center_gain(center_gain),
        .right_offset(right_offset), .right_gain(right_gain), .mode_setting(mode_setting));
    lsce_ctrl_model u_ctrl (.mclk(mclk), .serial_in(serial_in), .pixel_sel(pixel_sel),
        .pixel_code(pixel_code));
    function automatic logic [7:0] exp_px(input int i);
        logic [7:0] v;
        v = i[7:0];
        return {v[6:0], 1'b0} ^ 8'h5a;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Counts clocks up to the start bit, then takes the data bits and the stop bit.
    task automatic rx_frame(output int n, output logic [7:0] b);
        n = 0;
        do begin @(posedge mclk); #1; n++; end while (serial_out !== 1'b0 && n < 3000);
        for (int i = 0; i < 8; i++) begin
            tick(1);
            b[i] = serial_out;
        end
        tick(1);
        `CHK(serial_out, 1'b1)
    endtask
    task automatic report_and_stop;
        if (mismatches == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #(40 * 40000);
        mismatches++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        tick(1);
        `CHK(serial_out_valid, 1'b0)
        u_ctrl.idle(12);
        u_ctrl.send_break(12);
        u_ctrl.idle(2);
        u_ctrl.send_byte(`LSCE_CMD_MAIN_RESET, 0);
        lat = 0;
        do begin @(posedge mclk); #1; lat++; end while (serial_out_valid !== 1'b1 && lat < 99);
        `CHK(lat >= 30 && lat <= 32, 1'b1)
        `CHK(serial_out, 1'b1)
        `CHK(pix_reset, 1'b1)
        foreach (rows[r]) begin
            u_ctrl.send_byte({`LSCE_PFX_SETTING_STORE, rows[r][20:16]}, 0);
            u_ctrl.send_byte(rows[r][15:8], 6);
            u_ctrl.send_byte({`LSCE_PFX_SETTING_FETCH, rows[r][20:16]}, 0);
            rx_frame(lat, d);
            `CHK(lat, 5)
            `CHK(d, rows[r][7:0])
            tick(6);
        end
        `CHK(left_offset, 8'h81)
        `CHK(left_gain, 5'h1f)
        `CHK(right_offset, 8'hc3)
        `CHK(center_offset, 8'h7e)
        `CHK(center_gain, 5'h0a)
        `CHK(right_gain, 5'h15)
        u_ctrl.send_byte({`LSCE_PFX_SETTING_STORE, `LSCE_ADDR_MODE}, 0);
        u_ctrl.send_byte(8'h10, 0);
        tick(3);
        `CHK(sleep_mode, 1'b1)
        `CHK(mode_setting, 8'h10)
        u_ctrl.send_byte(`LSCE_CMD_CAPTURE_AND_STREAM, 0);
        tick(1);
        `CHK(capture_strobe, 1'b1)
        rx_frame(lat, d);
        `CHK(lat, 44)
        u_ctrl.send_byte(`LSCE_CMD_CANCEL_STREAM, 0);
        tick(2);
        for (int i = 0; i < 30; i++) begin
            `CHK(serial_out, 1'b1)
            tick(1);
        end
        `CHK(hold_valid, 1'b0)
        u_ctrl.send_byte({`LSCE_PFX_SETTING_STORE, `LSCE_ADDR_MODE}, 0);
        u_ctrl.send_byte(8'h00, 0);
        tick(3);
        `CHK(sleep_mode, 1'b0)
        // The analog side needs a millisecond to wake before image data counts.
        u_ctrl.idle(25000);
        u_ctrl.send_byte(`LSCE_CMD_BEGIN_EXPOSURE, 0);
        lat = 0;
        do begin @(posedge mclk); #1; lat++; end while (integrating !== 1'b1 && lat < 99);
        `CHK(lat, 23)
        `CHK(pix_reset, 1'b0)
        u_ctrl.send_byte(`LSCE_CMD_CAPTURE_EXPOSURE, 0);
        tick(1);
        `CHK({capture_strobe, hold_valid, integrating, pix_reset}, 4'hd)
        tick(1);
        `CHK(capture_strobe, 1'b0)
        // The whole capture is read out before the next capture is issued.
        u_ctrl.send_byte(`LSCE_CMD_STREAM_SAMPLES, 0);
        for (int i = 0; i < 102; i++) begin
            rx_frame(lat, d);
            `CHK(lat, (i == 0) ? 45 : 1)
            `CHK(d, exp_px(i))
        end
        for (int i = 0; i < 20; i++) begin
            tick(1);
            `CHK(serial_out, 1'b1)
        end
        `CHK(pixel_sel, 7'h65)
        u_ctrl.send_byte(`LSCE_CMD_CAPTURE_STREAM_RESTART, 0);
        fork
            rx_frame(lat, d);
            begin
                lat2 = 0;
                do begin @(posedge mclk); #1; lat2++; end while (integrating !== 1'b1 && lat2 < 99);
            end
        join
        `CHK(lat, 45)
        `CHK(lat2, 23)
        `CHK(d, exp_px(0))
        u_ctrl.send_byte(`LSCE_CMD_MAIN_RESET, 0);
        tick(2);
        `CHK({serial_out, hold_valid, integrating, pix_reset}, 4'h9)
        u_ctrl.send_byte({`LSCE_PFX_SETTING_STORE, `LSCE_ADDR_LEFT_OFFSET}, 0);
        u_ctrl.send_break(12);
        u_ctrl.idle(2);
        u_ctrl.send_byte(`LSCE_CMD_CAPTURE_EXPOSURE, 0);
        tick(1);
        `CHK(capture_strobe, 1'b1)
        `CHK(left_offset, 8'h81)
        u_ctrl.send_byte(8'hff, 6);
        u_ctrl.send_byte({`LSCE_PFX_SETTING_FETCH, `LSCE_ADDR_LEFT_OFFSET}, 0);
        rx_frame(lat, d);
        `CHK(lat, 5)
        `CHK(d, 8'h81)
        tick(6);
        report_and_stop();
    end
endmodule
